/* pio_port_pkg.sv */
// Purpose: shared constants and types of the parallel i/o port
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes:   offsets are byte addresses of aligned 32-bit registers
package pio_port_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets
  localparam logic [7:0] OFS_PORT_CTRL_EN    = 8'h00;
  localparam logic [7:0] OFS_PORT_CTRL_DIS   = 8'h04;
  localparam logic [7:0] OFS_PORT_CTRL_STAT  = 8'h08;
  localparam logic [7:0] OFS_OUT_EN_SET      = 8'h10;
  localparam logic [7:0] OFS_OUT_EN_CLR      = 8'h14;
  localparam logic [7:0] OFS_OUT_EN_STAT     = 8'h18;
  localparam logic [7:0] OFS_FILT_EN         = 8'h20;
  localparam logic [7:0] OFS_FILT_DIS        = 8'h24;
  localparam logic [7:0] OFS_FILT_STAT       = 8'h28;
  localparam logic [7:0] OFS_SET_OUT_LEVEL   = 8'h30;
  localparam logic [7:0] OFS_CLR_OUT_LEVEL   = 8'h34;
  localparam logic [7:0] OFS_OUT_LEVEL_STAT  = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL_STAT  = 8'h3C;
  localparam logic [7:0] OFS_IRQ_EN          = 8'h40;
  localparam logic [7:0] OFS_IRQ_DIS         = 8'h44;
  localparam logic [7:0] OFS_IRQ_MASK        = 8'h48;
  localparam logic [7:0] OFS_IRQ_STAT        = 8'h4C;
  localparam logic [7:0] OFS_PULLUP_DIS      = 8'h60;
  localparam logic [7:0] OFS_PULLUP_EN       = 8'h64;
  localparam logic [7:0] OFS_PULLUP_STAT     = 8'h68;
  localparam logic [7:0] OFS_PERIPH_SEL0     = 8'h70;
  localparam logic [7:0] OFS_PERIPH_SEL1     = 8'h74;
  localparam logic [7:0] OFS_GLITCH_SEL      = 8'h80;
  localparam logic [7:0] OFS_SLOWCLK_SEL     = 8'h84;
  localparam logic [7:0] OFS_SLOWCLK_STATE   = 8'h88;
  localparam logic [7:0] OFS_SLOWCLK_DIV     = 8'h8C;

  // divider field of the slow-clock divider register
  localparam int unsigned DIV_W   = 14;
  localparam int unsigned DIV_LSB = 0;

  // values after reset
  localparam logic [31:0] RST_PORT_CTRL = 32'hFFFFFFFF;
  localparam logic [31:0] RST_PULLUP    = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ZERO      = 32'h00000000;
  localparam logic [13:0] RST_DIV       = 14'h0000;

  // number of peripheral functions per pin
  localparam int unsigned NFUNC = 4;

  // one register-bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

endpackage

/* pio_port.sv */
// Purpose: parallel i/o port with change irq and input filters
// Assumes: pins and slow clock sampled in the mclk domain
// Notes:   set/clear registers act only on bits written as one
`timescale 1ns/100ps

module pio_port #(
  parameter int unsigned NPINS = 32
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rst,
  // register bus
  input  wire pio_port_pkg::bus_req_t        bus_req,
  output logic [31:0]                        rdata,
  // slow clock, sampled as a plain input
  input  wire logic                          slck,
  // pads
  input  wire logic [NPINS-1:0]              pin_in,
  output logic [NPINS-1:0]                   pin_out,
  output logic [NPINS-1:0]                   pin_oe,
  output logic [NPINS-1:0]                   pullup_en,
  // peripheral functions
  input  wire logic [3:0][NPINS-1:0]         func_out,
  input  wire logic [3:0][NPINS-1:0]         func_oe,
  output logic [NPINS-1:0]                   func_in,
  // interrupt
  output logic                               irq
);

  // refuse widths the 32-bit bus cannot carry
  if (NPINS < 1 || NPINS > 32)
  begin : g_chk
    $error("NPINS must lie in 1..32");
  end

  // configuration and state registers
  logic [NPINS-1:0] ctrl_ff, oen_ff, filt_ff, lvl_ff, imask_ff, isr_ff;
  logic [NPINS-1:0] pull_ff, sel0_ff, sel1_ff, slow_ff;
  logic [13:0]      div_ff;
  logic [NPINS-1:0] sync1_ff, sync2_ff, prev_raw_ff, glitch_ff;
  logic [NPINS-1:0] smp_ff, deb_ff, filt_prev_ff;
  logic [NPINS-1:0] filt_val;
  logic [NPINS-1:0] mux_out, mux_oe;
  logic [NPINS-1:0] wbits;
  logic [2:0]       slck_ff;
  logic [13:0]      scnt_ff;
  logic             tick_ff;
  logic [31:0]      nxt_rdata;
  logic [NPINS-1:0] change;

  // write decode helpers
  logic wr, rd;
  logic [7:0] a;
  assign wr    = bus_req.wr;
  assign rd    = bus_req.rd;
  assign a     = bus_req.addr;
  assign wbits = bus_req.wdata[NPINS-1:0];

  // port control: set by enable, cleared by disable
  always_ff @(posedge mclk)
  begin
    if (rst)
      ctrl_ff <= pio_port_pkg::RST_PORT_CTRL[NPINS-1:0];
    else if (wr && a == pio_port_pkg::OFS_PORT_CTRL_EN)
      ctrl_ff <= ctrl_ff | wbits;
    else if (wr && a == pio_port_pkg::OFS_PORT_CTRL_DIS)
      ctrl_ff <= ctrl_ff & ~wbits;
  end

  // direction
  always_ff @(posedge mclk)
  begin
    if (rst)
      oen_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
    else if (wr && a == pio_port_pkg::OFS_OUT_EN_SET)
      oen_ff <= oen_ff | wbits;
    else if (wr && a == pio_port_pkg::OFS_OUT_EN_CLR)
      oen_ff <= oen_ff & ~wbits;
  end

  // pull-ups, all on after reset
  always_ff @(posedge mclk)
  begin
    if (rst)
      pull_ff <= pio_port_pkg::RST_PULLUP[NPINS-1:0];
    else if (wr && a == pio_port_pkg::OFS_PULLUP_DIS)
      pull_ff <= pull_ff & ~wbits;
    else if (wr && a == pio_port_pkg::OFS_PULLUP_EN)
      pull_ff <= pull_ff | wbits;
  end

  // commanded output level
  always_ff @(posedge mclk)
  begin
    if (rst)
      lvl_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
    else if (wr && a == pio_port_pkg::OFS_SET_OUT_LEVEL)
      lvl_ff <= lvl_ff | wbits;
    else if (wr && a == pio_port_pkg::OFS_CLR_OUT_LEVEL)
      lvl_ff <= lvl_ff & ~wbits;
  end

  // input filter enable and kind of filter
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      filt_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
      slow_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
    end
    else if (wr)
    begin
      if (a == pio_port_pkg::OFS_FILT_EN)
        filt_ff <= filt_ff | wbits;
      if (a == pio_port_pkg::OFS_FILT_DIS)
        filt_ff <= filt_ff & ~wbits;
      if (a == pio_port_pkg::OFS_SLOWCLK_SEL)
        slow_ff <= slow_ff | wbits;
      if (a == pio_port_pkg::OFS_GLITCH_SEL)
        slow_ff <= slow_ff & ~wbits;
    end
  end

  // interrupt mask
  always_ff @(posedge mclk)
  begin
    if (rst)
      imask_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
    else if (wr && a == pio_port_pkg::OFS_IRQ_EN)
      imask_ff <= imask_ff | wbits;
    else if (wr && a == pio_port_pkg::OFS_IRQ_DIS)
      imask_ff <= imask_ff & ~wbits;
  end

  // peripheral select words and slow clock divider
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sel0_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
      sel1_ff <= pio_port_pkg::RST_ZERO[NPINS-1:0];
      div_ff  <= pio_port_pkg::RST_DIV;
    end
    else if (wr)
    begin
      if (a == pio_port_pkg::OFS_PERIPH_SEL0)
        sel0_ff <= wbits;
      if (a == pio_port_pkg::OFS_PERIPH_SEL1)
        sel1_ff <= wbits;
      if (a == pio_port_pkg::OFS_SLOWCLK_DIV)
        div_ff <= bus_req.wdata[pio_port_pkg::DIV_LSB +: 14];
    end
  end

  // pin synchroniser, glitch stage and raw history
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      // follow the pads in reset, so release brings no false change
      // (hold reset four clocks for the pipeline to settle)
      sync1_ff    <= pin_in;
      sync2_ff    <= sync1_ff;
      prev_raw_ff <= sync2_ff;
      glitch_ff   <= sync2_ff;
    end
    else
    begin
      sync1_ff    <= pin_in;
      sync2_ff    <= sync1_ff;
      prev_raw_ff <= sync2_ff;
      // accept a level once it has held two clocks
      glitch_ff   <= (sync2_ff & prev_raw_ff)
                   | (glitch_ff & (sync2_ff | prev_raw_ff));
    end
  end

  // slow clock edge counter: half-period tick of the divided clock
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slck_ff <= '0;
      scnt_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      slck_ff <= {slck_ff[1:0], slck};
      tick_ff <= 1'b0;
      if (slck_ff[1] && !slck_ff[2])
      begin
        if (scnt_ff >= div_ff)
        begin
          scnt_ff <= '0;
          tick_ff <= 1'b1;
        end
        else
          scnt_ff <= scnt_ff + 14'h0001;
      end
    end
  end

  // debounce: a level must match at two successive half-period ticks
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      // start settled on the pad level, not on a forced low
      smp_ff <= sync2_ff;
      deb_ff <= sync2_ff;
    end
    else if (tick_ff)
    begin
      smp_ff <= sync2_ff;
      deb_ff <= (sync2_ff & smp_ff) | (deb_ff & (sync2_ff | smp_ff));
    end
  end

  // per-pin filter choice and output multiplexer
  for (genvar i = 0; i < NPINS; i++)
  begin : g_pin
    logic [1:0] fsel;
    assign fsel = {sel1_ff[i], sel0_ff[i]};
    assign filt_val[i] = !filt_ff[i] ? sync2_ff[i] :
                         slow_ff[i]  ? deb_ff[i] : glitch_ff[i];
    assign mux_out[i]  = ctrl_ff[i] ? lvl_ff[i] : func_out[fsel][i];
    assign mux_oe[i]   = ctrl_ff[i] ? oen_ff[i] : func_oe[fsel][i];
  end

  // registered pad drive
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pin_out   <= '0;
      pin_oe    <= '0;
      pullup_en <= pio_port_pkg::RST_PULLUP[NPINS-1:0];
      func_in   <= '0;
    end
    else
    begin
      pin_out   <= mux_out;
      pin_oe    <= mux_oe;
      pullup_en <= pull_ff;
      func_in   <= sync2_ff;
    end
  end

  // change detection after the filter
  assign change = filt_val ^ filt_prev_ff;

  // change flags: read clears, a new change in the same cycle wins
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      filt_prev_ff <= filt_val;                    // no edge at release
      isr_ff       <= '0;
    end
    else
    begin
      filt_prev_ff <= filt_val;
      if (rd && a == pio_port_pkg::OFS_IRQ_STAT)
        isr_ff <= change;
      else
        isr_ff <= isr_ff | change;
    end
  end

  // level interrupt
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq <= 1'b0;
    else if (rd && a == pio_port_pkg::OFS_IRQ_STAT)
      irq <= |(change & imask_ff);
    else
      irq <= |((isr_ff | change) & imask_ff);
  end

  // read multiplexer
  always_comb
  begin
    nxt_rdata = '0;
    unique case (a)
      pio_port_pkg::OFS_PORT_CTRL_STAT: nxt_rdata[NPINS-1:0] = ctrl_ff;
      pio_port_pkg::OFS_OUT_EN_STAT:    nxt_rdata[NPINS-1:0] = oen_ff;
      pio_port_pkg::OFS_FILT_STAT:      nxt_rdata[NPINS-1:0] = filt_ff;
      pio_port_pkg::OFS_OUT_LEVEL_STAT: nxt_rdata[NPINS-1:0] = lvl_ff;
      pio_port_pkg::OFS_PIN_LEVEL_STAT: nxt_rdata[NPINS-1:0] = sync2_ff;
      pio_port_pkg::OFS_IRQ_MASK:       nxt_rdata[NPINS-1:0] = imask_ff;
      pio_port_pkg::OFS_IRQ_STAT:       nxt_rdata[NPINS-1:0] = isr_ff;
      pio_port_pkg::OFS_PULLUP_STAT:    nxt_rdata[NPINS-1:0] = pull_ff;
      pio_port_pkg::OFS_PERIPH_SEL0:    nxt_rdata[NPINS-1:0] = sel0_ff;
      pio_port_pkg::OFS_PERIPH_SEL1:    nxt_rdata[NPINS-1:0] = sel1_ff;
      pio_port_pkg::OFS_SLOWCLK_STATE:  nxt_rdata[NPINS-1:0] = slow_ff;
      pio_port_pkg::OFS_SLOWCLK_DIV:    nxt_rdata[13:0]      = div_ff;
      default:                          nxt_rdata = '0;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= '0;
    else
      rdata <= rd ? nxt_rdata : 32'h00000000;
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  port_enable_a: assert property (
    wr && a == pio_port_pkg::OFS_PORT_CTRL_EN |=> (ctrl_ff & $past(wbits))
      == $past(wbits)) else $error("port enable not taken");
  port_disable_a: assert property (
    wr && a == pio_port_pkg::OFS_PORT_CTRL_DIS |=> (ctrl_ff & $past(wbits))
      == '0) else $error("port disable not taken");
  dir_keep_a: assert property (
    wr && a == pio_port_pkg::OFS_OUT_EN_SET |=> (oen_ff & ~$past(wbits))
      == ($past(oen_ff) & ~$past(wbits))) else $error("zero bit changed");
  level_drive_a: assert property (
    wr && a == pio_port_pkg::OFS_SET_OUT_LEVEL |=> ##1
      ((pin_out & $past(wbits, 2) & $past(ctrl_ff)) ==
      ($past(wbits, 2) & $past(ctrl_ff)))) else $error("set level not driven");
  level_read_a: assert property (
    rd && a == pio_port_pkg::OFS_OUT_LEVEL_STAT |=>
      rdata[NPINS-1:0] == $past(lvl_ff)) else $error("level readback");
  pin_read_a: assert property (
    rd && a == pio_port_pkg::OFS_PIN_LEVEL_STAT |=>
      rdata[NPINS-1:0] == $past(pin_in, 3)) else $error("pin readback");
  change_flag_a: assert property (
    !filt_ff[0] && !$past(filt_ff[0]) && $changed(sync2_ff[0]) |=> isr_ff[0])
    else $error("change not flagged");
  read_clear_a: assert property (
    rd && a == pio_port_pkg::OFS_IRQ_STAT && change == '0 |=> isr_ff == '0)
    else $error("status not cleared by read");
  irq_level_a: assert property (
    irq == |(isr_ff & $past(imask_ff)))
    else $error("irq differs from pending enabled flags");
  pullup_rst_a: assert property (
    $rose(!rst) |-> pullup_en == pio_port_pkg::RST_PULLUP[NPINS-1:0])
    else $error("pull-up not on after reset");
  tick_gap_a: assert property (
    tick_ff |=> !tick_ff) else $error("tick longer than one cycle");

  change_irq_c: cover property (irq ##1 (rd && a ==
    pio_port_pkg::OFS_IRQ_STAT) ##1 !irq);
  debounce_c:   cover property (tick_ff && slow_ff[0] && filt_ff[0]);
  periph_c:     cover property (!ctrl_ff[0] && sel0_ff[0] && sel1_ff[0]);

endmodule // pio_port

/* pad_model.sv */
// Purpose: pad, button and pull-up model at the port's far side
// Assumes: buttons drive only where btn_en is set
// Notes:   an undriven pad with no pull-up toggles every mclk
`timescale 1ns/100ps
module pad_model (
  // clock
  input  wire logic        mclk,
  // design side of the pads
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pullup_en,
  // buttons
  input  wire logic [31:0] btn_en,
  input  wire logic [31:0] btn_lvl,
  // resolved pad level
  output logic [31:0]      pin_in
);
  logic [31:0] float_ff = 32'h00000000;

  // floating pads never hold a stable value
  always_ff @(posedge mclk)
  begin
    float_ff <= ~float_ff;
  end

  // driver first, then button, then pull-up, else floating
  assign pin_in = (pin_oe & pin_out)
                | (~pin_oe & btn_en & btn_lvl)
                | (~pin_oe & ~btn_en & pullup_en)
                | (~pin_oe & ~btn_en & ~pullup_en & float_ff);
endmodule // pad_model

/* tb_top.sv */
// Purpose: self-checking bench of the parallel i/o port
// Assumes: slow clock of 40 ns, divider 2 for debounce
// Notes:   register rows first, irq and debounce cases after
`timescale 1ns/100ps
module tb_top;
  typedef struct {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] ex;
  } row_t;
  localparam pio_port_pkg::bus_req_t IDLE = '0;
  logic                   mclk = 1'b0;
  logic                   rst = 1'b1;
  logic                   slck = 1'b0;
  pio_port_pkg::bus_req_t bus_req = '0;
  logic [31:0]            rdata, pin_in, pin_out, pin_oe, pullup_en;
  logic [31:0]            func_in, btn_en, btn_lvl, v;
  logic [3:0][31:0]       func_out, func_oe;
  logic                   irq;
  int                     failures = 0;
  int                     checked = 0;
  row_t rows [13] = '{
    '{8'h10, 32'h0F, 8'h18, 32'h0F},
    '{8'h14, 32'h03, 8'h18, 32'h0C},
    '{8'h30, 32'h0C, 8'h38, 32'h0C},
    '{8'h34, 32'h04, 8'h38, 32'h08},
    '{8'h60, 32'h0C, 8'h68, 32'hFFFFFFF3},
    '{8'h04, 32'h30, 8'h08, 32'hFFFFFFCF},
    '{8'h00, 32'h10, 8'h08, 32'hFFFFFFDF},
    '{8'h20, 32'h100, 8'h28, 32'h100},
    '{8'h84, 32'h100, 8'h88, 32'h100},
    '{8'h40, 32'h380, 8'h48, 32'h380},
    '{8'h8C, 32'h02, 8'h8C, 32'h02},
    '{8'h70, 32'h20, 8'h70, 32'h20},
    '{8'hFC, 32'h01, 8'hFC, 32'h00}};

  pio_port u_pio_port (.mclk(mclk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .slck(slck), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_en(pullup_en), .func_out(func_out),
    .func_oe(func_oe), .func_in(func_in), .irq(irq));
  pad_model u_pad_model (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_en(pullup_en), .btn_en(btn_en), .btn_lvl(btn_lvl),
    .pin_in(pin_in));

  // clocks
  initial
  begin
    forever #2 mclk = ~mclk;
  end
  initial
  begin
    forever #20 slck = ~slck;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req <= IDLE;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req <= IDLE;
    #1 d = rdata;
  endtask

  // bounded wait for the interrupt level
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (irq !== 1'b1)
    begin
      chk({31'h0, irq}, 32'h1);
      complete_run();
    end
  endtask

  initial
  begin
    btn_en = 32'h380;
    btn_lvl = 32'hFFFFFFFF;
    func_out = '0;
    func_oe = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk(pin_oe, 32'h0);
    chk(pullup_en, 32'hFFFFFFFF);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, v);
    chk(v, 32'hFFFFFFFF);
    // register rows
    foreach (rows[i])
    begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, v);
      chk(v, rows[i].ex);
    end
    chk(pin_oe & 32'h0C, 32'h0C);
    chk(pin_out & 32'h0C, 32'h08);
    chk(pullup_en & 32'h0C, 32'h0);
    rd(8'h3C, v);
    chk(v, 32'hFFFFFFFB);
    chk(func_in, 32'hFFFFFFFB);
    // peripheral function 1 on pin 5
    @(posedge mclk);
    func_out[1] <= 32'h20;
    func_oe[1] <= 32'h20;
    repeat (4) @(posedge mclk);
    #1 chk(pin_oe & 32'h20, 32'h20);
    chk(pin_out & 32'h20, 32'h20);
    // press then release pin 9
    rd(8'h4C, v);
    @(posedge mclk);
    btn_lvl[9] <= 1'b0;
    wait_irq();
    repeat (5) @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h1);
    rd(8'h4C, v);
    chk(v, 32'h200);
    chk({31'h0, irq}, 32'h0);
    rd(8'h4C, v);
    chk(v, 32'h0);
    @(posedge mclk);
    btn_lvl[9] <= 1'b1;
    wait_irq();
    rd(8'h4C, v);
    chk(v, 32'h200);
    // masked pin 7 changes, no interrupt
    wr(8'h44, 32'h080);
    @(posedge mclk);
    btn_lvl[7] <= 1'b0;
    repeat (10) @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h0);
    rd(8'h4C, v);
    chk(v, 32'h080);
    // debounce on pin 8: short pulse dropped, long level taken
    @(posedge mclk);
    btn_lvl[8] <= 1'b0;
    repeat (25) @(posedge mclk);
    btn_lvl[8] <= 1'b1;
    repeat (100) @(posedge mclk);
    rd(8'h4C, v);
    chk(v, 32'h0);
    @(posedge mclk);
    btn_lvl[8] <= 1'b0;
    repeat (100) @(posedge mclk);
    rd(8'h4C, v);
    chk(v, 32'h100);
    // mid-run reset: defaults back, no false change at release
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk(pin_oe, 32'h0);
    chk(pullup_en, 32'hFFFFFFFF);
    chk({31'h0, irq}, 32'h0);
    rd(8'h08, v);
    chk(v, 32'hFFFFFFFF);
    rd(8'h4C, v);
    chk(v, 32'h0);
    complete_run();
  end
endmodule // tb_top
